// ==== design/gzo_consts.vh ====
`ifndef GZO_CONSTS_VH
`define GZO_CONSTS_VH
// ==========================================
// Register byte offsets
`define GZO_OFF_CTRL 8'h00
`define GZO_OFF_TYPES 8'h04
`define GZO_OFF_FAULT 8'h08
`define GZO_OFF_STAT 8'h0c
// ==========================================
// Control fields and reset values
`define GZO_CB_BURST 0
`define GZO_CB_RS485 1
`define GZO_CB_HOTC 2
`define GZO_CB_V24EN 3
`define GZO_CB_ADDR 8
`define GZO_ADDR_RST 8'h30
`define GZO_TYPES_RST 20'h00000
// ==========================================
// Station types
`define GZO_TY_NONE 2'h0
`define GZO_TY_SINGLE 2'h1
`define GZO_TY_DUAL 2'h2
`define GZO_TY_BAD 2'h3
// ==========================================
// Offset limits and station list lengths
`define GZO_ZMIN 10'sh3a6
`define GZO_ZMAX 10'sh0a5
`define GZO_AMIN 11'sh781
`define GZO_AMAX 11'sh07f
`define GZO_LIST_HOT 4'h5
`define GZO_LIST_ALL 4'ha
// ==========================================
// Characters
`define GZO_CH_CR 8'h0d
`define GZO_CH_SP 8'h20
`define GZO_CH_Q 8'h3f
`define GZO_CH_DASH 8'h2d
`define GZO_CH_0 8'h30
`define GZO_CH_1 8'h31
`define GZO_CH_8 8'h38
`define GZO_CH_9 8'h39
`define GZO_CH_A 8'h41
`define GZO_CH_C 8'h43
`define GZO_CH_D 8'h44
`define GZO_CH_F 8'h46
`define GZO_CH_N 8'h4e
`define GZO_CH_O 8'h4f
`define GZO_CH_P 8'h50
`define GZO_CH_R 8'h52
`define GZO_CH_Z 8'h5a
`endif

// ==== design/gzo_mem.v ====
// ==========================================
// Offset store, registered read
module gzo_mem #(
	parameter AW = 4,
	parameter DW = 9
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule // gzo_mem

// ==== design/gzo_cmd.v ====
`include "gzo_consts.vh"
// ==========================================
// What this block does
// RULE1 - Capture acks only stations one to eight
// RULE2 - Capture outside zero mode only stores
// RULE3 - Capture in zero mode applies at once
// RULE4 - Out-of-window capture sets fault, stores limit
// RULE5 - Fault flags stay until host clears
// RULE6 - Enable command enters zero mode, acks
// RULE7 - Disable leaves zero mode, stops auto
// RULE8 - Auto-on only in zero mode
// RULE9 - Auto offset cancels negative readings
// RULE10 - Auto-off keeps mode and last offset
// RULE11 - Clear zeroes all offsets
// RULE12 - Report refused in burst mode
// RULE13 - Report lists values then flag digits
// RULE14 - Zero -90..165, atmosphere -127..127
// RULE15 - Slots by station, dual takes two
// RULE16 - Flag digit one when range exceeded
// RULE17 - Atmosphere off/on keeps stored values
// RULE18 - Neutral preset keeps enable unchanged
// RULE19 - Host sends station and absolute pressure
// RULE20 - Station list length five or ten
// RULE21 - Multidrop address match, case sensitive
// RULE22 - Interlock gates filament, else N/A
// RULE23 - Rejects answer letter, question mark, CR
// RULE24 - Plain accepts answer A and CR
// RULE25 - State changes only on complete commands
module gzo_cmd #(
	parameter RW = 10,
	parameter [10:0] ATM_REF = 11'h2f8
) (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire [7:0] rx_data,
	input wire rx_valid,
	output wire rx_ready,
	output reg [7:0] tx_data,
	output reg tx_valid,
	input wire tx_ready,
	input wire [8*RW-1:0] raw_reading,
	output reg [RW:0] corr_value,
	output reg [2:0] corr_station,
	output reg corr_valid,
	input wire fil_req,
	input wire v24_sig,
	output reg fil_en
);
	localparam S_IDLE = 8'h01;
	localparam S_EXEC = 8'h02;
	localparam S_RESP = 8'h04;
	localparam S_RLOAD = 8'h08;
	localparam S_RWAIT = 8'h10;
	localparam S_RCHR = 8'h20;
	localparam S_FLAG = 8'h40;
	localparam S_CLR = 8'h80;

	// ==========================================
	// Register file
	reg burst;
	reg rs485;
	reg hotc;
	reg v24en;
	reg [7:0] addr;
	reg [19:0] types;
	reg [15:0] flt;
	reg [15:0] flt_set;
	reg zm;
	reg az;
	reg atm_en;
	wire apb_wr;
	wire apb_setup;
	wire [15:0] flt_w1c;
	wire [1:0] v24code;
	wire [3:0] list_cnt;
	wire [31:0] stat_word;

	// Zero-wait slave: every access phase completes at once
	assign pready = 1'b1;
	assign apb_wr = psel & penable & pwrite;
	assign apb_setup = psel & ~penable;
	assign flt_w1c = (apb_wr && paddr == `GZO_OFF_FAULT) ? pwdata[15:0] : 16'h0000;
	// RULE22 - signal report code
	assign v24code = v24en ? {1'b0, v24_sig} : 2'h2;
	// RULE20 - list length
	assign list_cnt = hotc ? `GZO_LIST_HOT : `GZO_LIST_ALL;
	assign stat_word = {23'h000000, list_cnt, v24code, atm_en, az, zm};

	always @(posedge clk) begin
		if (sys_rst) begin
			burst <= 1'b0;
			rs485 <= 1'b0;
			hotc <= 1'b0;
			v24en <= 1'b0;
			addr <= `GZO_ADDR_RST;
			types <= `GZO_TYPES_RST;
		end else if (apb_wr && paddr == `GZO_OFF_CTRL) begin
			burst <= pwdata[`GZO_CB_BURST];
			rs485 <= pwdata[`GZO_CB_RS485];
			hotc <= pwdata[`GZO_CB_HOTC];
			v24en <= pwdata[`GZO_CB_V24EN];
			addr <= pwdata[`GZO_CB_ADDR +: 8];
		end else if (apb_wr && paddr == `GZO_OFF_TYPES) begin
			types <= pwdata[19:0];
		end
	end

	// Read data is latched in the setup cycle so it is stable through access
	always @(posedge clk) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			pslverr <= 1'b0;
			case (paddr)
				`GZO_OFF_CTRL: prdata <= {16'h0000, addr, 4'h0, v24en, hotc, rs485, burst};
				`GZO_OFF_TYPES: prdata <= {12'h000, types};
				`GZO_OFF_FAULT: prdata <= {16'h0000, flt};
				`GZO_OFF_STAT: prdata <= stat_word;
				default: begin
					prdata <= 32'h00000000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================
	// Sticky fault flags, set beats clear
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_flt
			always @(posedge clk) begin
				if (sys_rst)
					flt[g] <= 1'b0;
				// RULE5 - sticky until cleared
				else
					flt[g] <= flt_set[g] | (flt[g] & ~flt_w1c[g]);
			end
		end
	endgenerate

	// ==========================================
	// Filament interlock
	always @(posedge clk) begin
		if (sys_rst)
			fil_en <= 1'b0;
		// RULE22 - interlock gating
		else
			fil_en <= fil_req & (~v24en | v24_sig);
	end

	// ==========================================
	// Command engine state
	reg [7:0] st;
	reg [7:0] cb [0:4];
	reg [2:0] cn;
	reg ovf;
	reg adr_seen;
	reg adr_ok;
	reg [23:0] rsp;
	reg [1:0] rsn;
	reg [2:0] rs;
	reg ra;
	reg [2:0] ci;
	reg [4:0] clr_i;
	reg [3:0] mra;
	reg mwe;
	reg [3:0] mwa;
	reg [8:0] mwd;
	wire [8:0] mrd;
	reg [2:0] sw_st;
	reg [1:0] sw_ph;
	reg [8:0] sw_z;

	gzo_mem #(.AW(4), .DW(9)) u_mem (
		.clk(clk),
		.we(mwe),
		.waddr(mwa),
		.wdata(mwd),
		.raddr(mra),
		.rdata(mrd)
	);

	assign rx_ready = st[0];
	wire tx_busy = tx_valid & ~tx_ready;

	// Report slot walk
	wire [1:0] ty = types[{rs, 1'b0} +: 2];
	wire slot_ok = (ty == `GZO_TY_SINGLE && !ra) || ty == `GZO_TY_DUAL;
	wire nx_ra = !ra && ty == `GZO_TY_DUAL;
	wire last = !nx_ra && rs == 3'h7;

	// Decimal formatting of a stored value
	wire neg = mrd[8];
	wire [8:0] nv = 9'h000 - mrd;
	wire [7:0] mag = neg ? nv[7:0] : mrd[7:0];
	wire [7:0] q100 = mag / 8'h64;
	wire [7:0] q10 = mag / 8'h0a;
	wire [7:0] d_t = q10 % 8'h0a;
	wire [7:0] d_o = mag % 8'h0a;
	wire [7:0] c_h = `GZO_CH_0 + q100;
	wire [7:0] c_t = `GZO_CH_0 + d_t;
	wire [7:0] c_o = `GZO_CH_0 + d_o;
	wire lng = neg && q100 != 8'h00;
	reg [7:0] rch;
	wire rch_end = (ci == 3'h6 && !lng) || ci == 3'h7;

	always @* begin
		case (ci)
			3'h0: rch = `GZO_CH_1 + {5'h00, rs};
			3'h1: rch = ra ? `GZO_CH_A : `GZO_CH_Z;
			3'h2: rch = `GZO_CH_SP;
			3'h3: rch = neg ? `GZO_CH_DASH : c_h;
			3'h4: rch = lng ? c_h : c_t;
			3'h5: rch = lng ? c_t : c_o;
			3'h6: rch = lng ? c_o : `GZO_CH_SP;
			default: rch = `GZO_CH_SP;
		endcase
	end

	// Capture operand
	wire [3:0] zn = cb[1][3:0] - 4'h1;
	wire zn_ok = cb[1] >= `GZO_CH_1 && cb[1] <= `GZO_CH_8;
	wire signed [RW-1:0] rz = raw_reading[zn[2:0]*RW +: RW];
	wire z_lo = rz < `GZO_ZMIN;
	wire z_hi = rz > `GZO_ZMAX;
	localparam [9:0] ZMIN_W = `GZO_ZMIN;
	localparam [9:0] ZMAX_W = `GZO_ZMAX;
	localparam [10:0] AMIN_W = `GZO_AMIN;
	localparam [10:0] AMAX_W = `GZO_AMAX;
	wire [8:0] zmin = ZMIN_W[8:0];
	wire [8:0] zmax = ZMAX_W[8:0];
	wire [8:0] rz_c = z_lo ? zmin : (z_hi ? zmax : rz[8:0]);

	// Atmosphere operand
	wire dig2 = cb[2] >= `GZO_CH_0 && cb[2] <= `GZO_CH_9;
	wire dig3 = cb[3] >= `GZO_CH_0 && cb[3] <= `GZO_CH_9;
	wire dig4 = cb[4] >= `GZO_CH_0 && cb[4] <= `GZO_CH_9;
	wire [9:0] pv = {6'h00, cb[2][3:0]} * 10'h064 + {6'h00, cb[3][3:0]} * 10'h00a
		+ {6'h00, cb[4][3:0]};
	wire signed [10:0] ad = $signed({1'b0, pv}) - $signed(ATM_REF);
	wire [8:0] amin = AMIN_W[8:0];
	wire [8:0] amax = AMAX_W[8:0];
	wire a_lo = ad < `GZO_AMIN;
	wire a_hi = ad > `GZO_AMAX;
	wire [8:0] ad_c = a_lo ? amin : (a_hi ? amax : ad[8:0]);
	wire [1:0] aty = types[{zn[2:0], 1'b0} +: 2];

	// Background sweep operands
	wire signed [RW-1:0] sw_raw = raw_reading[sw_st*RW +: RW];
	wire [1:0] sw_ty = types[{sw_st, 1'b0} +: 2];
	wire sw_app = sw_ty == `GZO_TY_SINGLE || sw_ty == `GZO_TY_DUAL;
	wire signed [RW:0] zsub = zm ? {{(RW-8){sw_z[8]}}, sw_z} : 11'sh000;
	wire signed [RW:0] asub = (atm_en && sw_ty == `GZO_TY_DUAL) ?
		{{(RW-8){mrd[8]}}, mrd} : 11'sh000;
	wire signed [RW:0] sw_corr = {sw_raw[RW-1], sw_raw} - zsub - asub;
	wire sw_neg = sw_raw < $signed({sw_z[8], sw_z});
	wire sw_lo = sw_raw < `GZO_ZMIN;
	wire [8:0] sw_c = sw_lo ? zmin : sw_raw[8:0];

	task send(input [7:0] c);
		begin
			tx_valid <= 1'b1;
			tx_data <= c;
		end
	endtask

	task rej(input [7:0] l);
		begin
			rsp <= {l, `GZO_CH_Q, `GZO_CH_CR};
			rsn <= 2'h3;
		end
	endtask

	// RULE15 - ascending slots, dual takes two
	task adv(input [7:0] done_st, input [7:0] cont_st);
		begin
			if (nx_ra) begin
				ra <= 1'b1;
				st <= cont_st;
			end else begin
				ra <= 1'b0;
				rs <= rs + 3'h1;
				st <= last ? done_st : cont_st;
			end
		end
	endtask

	// ==========================================
	// Main sequencer
	always @(posedge clk) begin
		if (sys_rst) begin
			st <= S_IDLE;
			cn <= 3'h0;
			ovf <= 1'b0;
			adr_seen <= 1'b0;
			adr_ok <= 1'b0;
			rsp <= 24'h000000;
			rsn <= 2'h0;
			rs <= 3'h0;
			ra <= 1'b0;
			ci <= 3'h0;
			clr_i <= 5'h00;
			mra <= 4'h0;
			mwe <= 1'b0;
			mwa <= 4'h0;
			mwd <= 9'h000;
			zm <= 1'b0;
			az <= 1'b0;
			atm_en <= 1'b0;
			flt_set <= 16'h0000;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			sw_st <= 3'h0;
			sw_ph <= 2'h0;
			sw_z <= 9'h000;
			corr_value <= 11'h000;
			corr_station <= 3'h0;
			corr_valid <= 1'b0;
		end else begin
			mwe <= 1'b0;
			flt_set <= 16'h0000;
			corr_valid <= 1'b0;
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			// Sweep only runs while idle, so it never fights a command for the store
			if (!st[0])
				sw_ph <= 2'h0;
			case (st)
				S_IDLE: begin
					sw_ph <= sw_ph + 2'h1;
					case (sw_ph)
						2'h0: mra <= {1'b0, sw_st};
						2'h1: mra <= {1'b1, sw_st};
						2'h2: sw_z <= mrd;
						default: begin
							corr_value <= sw_corr;
							corr_station <= sw_st;
							corr_valid <= 1'b1;
							sw_st <= sw_st + 3'h1;
							// RULE9 - cancel negative reading
							if (az && zm && sw_app && sw_neg) begin
								mwe <= 1'b1;
								mwa <= {1'b0, sw_st};
								mwd <= sw_c;
								flt_set[sw_st] <= sw_lo;
							end
						end
					endcase
					// RULE25 - act only on CR
					if (rx_valid) begin
						if (rx_data == `GZO_CH_CR) begin
							st <= S_EXEC;
						end else if (rs485 && !adr_seen) begin
							adr_seen <= 1'b1;
							// RULE21 - exact address match
							adr_ok <= rx_data == addr;
						end else if (cn < 3'h5) begin
							cb[cn] <= rx_data;
							cn <= cn + 3'h1;
						end else begin
							ovf <= 1'b1;
						end
					end
				end
				S_EXEC: begin
					cn <= 3'h0;
					ovf <= 1'b0;
					adr_seen <= 1'b0;
					adr_ok <= 1'b0;
					st <= S_RESP;
					// RULE24 - default accept answer
					rsp <= {`GZO_CH_A, `GZO_CH_CR, 8'h00};
					rsn <= 2'h2;
					// RULE23 - lettered rejects
					if (rs485 && !adr_ok) begin
						st <= S_IDLE;
					end else if (ovf) begin
						rej(`GZO_CH_O);
					end else if (cn == 3'h2 && cb[0] == `GZO_CH_Z) begin
						case (cb[1])
							// RULE6 - enter zero mode
							`GZO_CH_N: zm <= 1'b1;
							// RULE7 - leave mode, stop auto
							`GZO_CH_F: begin
								zm <= 1'b0;
								az <= 1'b0;
							end
							// RULE8 - auto only in zero mode
							`GZO_CH_A: begin
								if (zm)
									az <= 1'b1;
								else
									rej(`GZO_CH_D);
							end
							// RULE10 - auto off, offsets kept
							`GZO_CH_O: az <= 1'b0;
							// RULE11 - clear all offsets
							`GZO_CH_C: begin
								clr_i <= 5'h00;
								st <= S_CLR;
							end
							default: begin
								// RULE1 - station range check
								if (!zn_ok) begin
									rej(`GZO_CH_N);
								end else begin
									// RULE2 - offset stored, applied in zero mode
									// RULE3 - sweep applies it at once
									mwe <= 1'b1;
									mwa <= {1'b0, zn[2:0]};
									// RULE4 - clamp and flag
									mwd <= rz_c;
									flt_set[zn[2:0]] <= z_lo | z_hi;
								end
							end
						endcase
					end else if (cn == 3'h2 && cb[0] == `GZO_CH_O && cb[1] == `GZO_CH_Z) begin
						// RULE12 - no report in burst
						if (burst) begin
							rej(`GZO_CH_D);
						end else begin
							rs <= 3'h0;
							ra <= 1'b0;
							st <= S_RLOAD;
						end
					end else if (cn == 3'h2 && cb[0] == `GZO_CH_A) begin
						case (cb[1])
							// RULE17 - enable only, values kept
							`GZO_CH_F: atm_en <= 1'b0;
							`GZO_CH_N: atm_en <= 1'b1;
							// RULE18 - neutral values, enable untouched
							`GZO_CH_P: begin
								clr_i <= 5'h08;
								st <= S_CLR;
							end
							default: rej(`GZO_CH_R);
						endcase
					end else if (cn == 3'h5 && cb[0] == `GZO_CH_A) begin
						// RULE19 - absolute pressure expected
						if (!(dig2 && dig3 && dig4)) begin
							rej(`GZO_CH_C);
						end else if (!zn_ok) begin
							rej(`GZO_CH_N);
						end else if (aty != `GZO_TY_DUAL) begin
							rej(`GZO_CH_A);
						end else begin
							mwe <= 1'b1;
							mwa <= {1'b1, zn[2:0]};
							// RULE14 - atmosphere limits
							mwd <= ad_c;
							flt_set[{1'b1, zn[2:0]}] <= a_lo | a_hi;
						end
					end else begin
						rej(`GZO_CH_R);
					end
				end
				S_CLR: begin
					mwe <= 1'b1;
					mwa <= clr_i[3:0];
					mwd <= 9'h000;
					clr_i <= clr_i + 5'h01;
					if (clr_i == 5'h0f)
						st <= S_RESP;
				end
				S_RESP: begin
					if (!tx_busy) begin
						send(rsp[23:16]);
						rsp <= {rsp[15:0], 8'h00};
						rsn <= rsn - 2'h1;
						if (rsn == 2'h1)
							st <= S_IDLE;
					end
				end
				S_RLOAD: begin
					if (slot_ok) begin
						mra <= {ra, rs};
						st <= S_RWAIT;
					end else begin
						adv(S_FLAG, S_RLOAD);
					end
				end
				S_RWAIT: begin
					ci <= 3'h0;
					st <= S_RCHR;
				end
				S_RCHR: begin
					// RULE13 - value, then space
					if (!tx_busy) begin
						send(rch);
						ci <= ci + 3'h1;
						if (rch_end)
							adv(S_FLAG, S_RLOAD);
					end
				end
				S_FLAG: begin
					if (!slot_ok) begin
						adv(S_RESP, S_FLAG);
					end else if (!tx_busy) begin
						// RULE16 - one digit per slot
						send(`GZO_CH_0 + {7'h00, flt[{ra, rs}]});
						adv(S_RESP, S_FLAG);
					end
					rsp <= {`GZO_CH_CR, 16'h0000};
					rsn <= 2'h1;
				end
				default: st <= S_IDLE;
			endcase
		end
	end
endmodule // gzo_cmd

// ==== verification/gzo_cmd_properties.sv ====
`include "gzo_consts.vh"
// ==========================================
// Port checks for the command block
module gzo_cmd_props (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire [7:0] rx_data,
	input wire rx_valid,
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	input wire tx_ready,
	input wire fil_req,
	input wire v24_sig,
	input wire fil_en
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [3:0] cfg;
	wire fil_ok = fil_req && (!cfg[`GZO_CB_V24EN] || v24_sig);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Shadow of the control bits, so no internal probe is needed
	always @(posedge clk) begin
		if (sys_rst)
			cfg <= 4'h0;
		else if (psel && penable && pwrite && paddr == `GZO_OFF_CTRL)
			cfg <= pwdata[3:0];
	end
	// Multidrop framing may drop a command silently, so only plain mode counts
	sequence cr_in;
		rx_valid && rx_ready && rx_data == `GZO_CH_CR && !cfg[`GZO_CB_RS485];
	endsequence
	sequence q_out;
		tx_valid && tx_ready && tx_data == `GZO_CH_Q;
	endsequence
	// ==========================================
	// Assertions
	reject_end_a: assert property (q_out |=> tx_valid && tx_data == `GZO_CH_CR)
		else $error("reject not closed by CR");
	answer_time_a: assert property (cr_in |=> !tx_valid ##[1:29] tx_valid)
		else $error("no answer in time");
	rx_block_a: assert property (cr_in |=> !rx_ready)
		else $error("input open while busy");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("answer byte lost");
	unmapped_err_a: assert property (psel && !penable && paddr >= 8'h10 |=>
		pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (psel && !penable && paddr < 8'h10 && paddr[1:0] == 2'h0 |=>
		!pslverr)
		else $error("mapped access refused");
	list_len_a: assert property (psel && !penable && paddr == `GZO_OFF_STAT |=>
		prdata[8:5] == ($past(cfg[`GZO_CB_HOTC]) ? `GZO_LIST_HOT : `GZO_LIST_ALL))
		else $error("station list count wrong");
	fil_gate_a: assert property (!$past(sys_rst) |-> fil_en == $past(fil_ok))
		else $error("filament gate wrong");
endmodule // gzo_cmd_props
bind gzo_cmd gzo_cmd_props i_gzo_cmd_props (
	.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pslverr,
	.rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .fil_req, .v24_sig, .fil_en
);

// ==== verification/gzo_host_model.sv ====
// ==========================================
// Host end of the serial command link
module gzo_host_model (
	input wire clk,
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	bit slow = 1'b0;
	string got = "";
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end
	// A stalling sink proves each answer byte waits to be taken
	always @(posedge clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready)
			got = {got, $sformatf("%c", tx_data)};
	end
	task automatic cmd(input string c, output string a);
		int n;
		c = {c, "\r"};
		got = "";
		for (int i = 0; i < c.len(); i++) begin
			rx_data <= c[i];
			rx_valid <= 1'b1;
			@(negedge clk);
			while (rx_ready !== 1'b1)
				@(negedge clk);
			@(posedge clk);
		end
		// Released line shows the inverse, never a stale byte
		rx_valid <= 1'b0;
		rx_data <= ~c[c.len()-1];
		n = 0;
		while (n < 400 && (got.len() == 0 || got[got.len()-1] != 8'h0d)) begin
			@(negedge clk);
			n++;
		end
		a = got;
		@(posedge clk);
	endtask
endmodule // gzo_host_model

// ==== verification/gzo_cmd_tb_top.sv ====
`include "gzo_consts.vh"
`define CHK(g, e) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
// ==========================================
// Self-checking bench for the command block
module gzo_cmd_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	int failures = 0;
	int cmp_count = 0;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [79:0] raw_reading = 80'h0;
	logic fil_req = 1'b0;
	logic v24_sig = 1'b0;
	logic [31:0] rdat;
	logic rerr;
	logic fil_s;
	wire [31:0] prdata;
	wire pready, pslverr, rx_ready, rx_valid, tx_valid, tx_ready, corr_valid, fil_en;
	wire [7:0] rx_data, tx_data;
	wire [10:0] corr_value;
	wire [2:0] corr_station;
	gzo_cmd i_gzo_cmd (
		.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready,
		.raw_reading, .corr_value, .corr_station, .corr_valid, .fil_req, .v24_sig, .fil_en
	);
	gzo_host_model i_gzo_host_model (
		.clk, .rx_ready, .tx_data, .tx_valid, .rx_data, .rx_valid, .tx_ready
	);
	initial begin
		forever #2 clk = ~clk;
	end
	// ==========================================
	// Shared tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(negedge clk);
		while (pready !== 1'b1)
			@(negedge clk);
		fil_s = fil_en;
		@(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic stat_is(input logic [2:0] e);
		apb(1'b0, `GZO_OFF_STAT, 32'h0);
		`CHK(rdat[2:0], e)
	endtask
	task automatic ask(input string c, input string e);
		string a;
		i_gzo_host_model.cmd(c, a);
		cmp_count++;
		if (a != e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask
	// The first pulse may still carry the old reading, so take the second
	task automatic corr_is(input logic [2:0] s, input logic [10:0] e);
		int n;
		n = 0;
		repeat (2) begin
			@(negedge clk);
			while (!(corr_valid === 1'b1 && corr_station === s) && n < 200) begin
				@(negedge clk);
				n++;
			end
		end
		`CHK(corr_value, e)
		@(posedge clk);
	endtask
	task automatic end_sim;
		$display("counts: %0d compared, %0d bad", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs;
		apb(1'b0, `GZO_OFF_CTRL, 32'h0);
		`CHK(rdat, 32'h3000)
		apb(1'b0, `GZO_OFF_STAT, 32'h0);
		`CHK(rdat, 32'h150)
		apb(1'b1, 8'h40, 32'h1);
		`CHK({rerr, rdat}, 33'h100000000)
		$display("done: registers");
	endtask
	task automatic t_fil;
		fil_req <= 1'b1;
		apb(1'b1, `GZO_OFF_CTRL, 32'h3008);
		stat_is(3'h0);
		`CHK({rdat[4:3], fil_s}, 3'h0)
		v24_sig <= 1'b1;
		stat_is(3'h0);
		`CHK({rdat[4:3], fil_s}, 3'h3)
		v24_sig <= 1'b0;
		apb(1'b1, `GZO_OFF_CTRL, 32'h3004);
		stat_is(3'h0);
		`CHK({rdat[8:3], fil_s}, 7'h2d)
		apb(1'b1, `GZO_OFF_CTRL, 32'h3000);
		fil_req <= 1'b0;
		$display("done: filament gate");
	endtask
	task automatic t_zero;
		string c[6] = '{"Z0", "Z9", "ZA", "QQ", "ZZZZZZ", "Z8"};
		string e[6] = '{"N?\r", "N?\r", "D?\r", "R?\r", "O?\r", "A\r"};
		ask("ZC", "A\r");
		i_gzo_host_model.slow = 1'b1;
		foreach (c[i])
			ask(c[i], e[i]);
		i_gzo_host_model.slow = 1'b0;
		apb(1'b1, `GZO_OFF_TYPES, 32'h1);
		raw_reading[9:0] <= 10'h014;
		ask("Z1", "A\r");
		corr_is(3'h0, 11'h014);
		ask("ZN", "A\r");
		stat_is(3'h1);
		corr_is(3'h0, 11'h000);
		raw_reading[9:0] <= 10'h01e;
		ask("Z1", "A\r");
		corr_is(3'h0, 11'h000);
		ask("ZA", "A\r");
		stat_is(3'h3);
		raw_reading[9:0] <= 10'h3ce;
		corr_is(3'h0, 11'h000);
		ask("ZO", "A\r");
		raw_reading[9:0] <= 10'h00a;
		corr_is(3'h0, 11'h03c);
		ask("ZF", "A\r");
		stat_is(3'h0);
		corr_is(3'h0, 11'h00a);
		ask("ZN", "A\r");
		corr_is(3'h0, 11'h03c);
		$display("done: zero modes");
	endtask
	task automatic t_offs;
		apb(1'b1, `GZO_OFF_TYPES, 32'h6);
		raw_reading[19:0] <= 20'he70c8;
		ask("Z1", "A\r");
		ask("OZ", "1Z 165 1A 000 2Z 000 100\r");
		ask("Z2", "A\r");
		raw_reading[9:0] <= 10'h005;
		ask("Z1", "A\r");
		apb(1'b0, `GZO_OFF_FAULT, 32'h0);
		`CHK(rdat, 32'h3)
		ask("A1800", "A\r");
		ask("A2800", "A?\r");
		ask("AN", "A\r");
		ask("OZ", "1Z 005 1A 040 2Z -90 101\r");
		raw_reading[9:0] <= 10'h064;
		corr_is(3'h0, 11'h037);
		ask("AF", "A\r");
		stat_is(3'h1);
		corr_is(3'h0, 11'h05f);
		ask("AN", "A\r");
		corr_is(3'h0, 11'h037);
		ask("AP", "A\r");
		stat_is(3'h5);
		corr_is(3'h0, 11'h05f);
		apb(1'b1, `GZO_OFF_FAULT, 32'h1);
		apb(1'b1, `GZO_OFF_CTRL, 32'h3001);
		ask("OZ", "D?\r");
		apb(1'b1, `GZO_OFF_CTRL, 32'h3000);
		ask("ZC", "A\r");
		ask("OZ", "1Z 000 1A 000 2Z 000 001\r");
		$display("done: offsets and report");
	endtask
	task automatic t_addr;
		apb(1'b1, `GZO_OFF_CTRL, 32'h6202);
		ask("bZF", "A\r");
		ask("BZN", "");
		stat_is(3'h4);
		apb(1'b1, `GZO_OFF_CTRL, 32'h3000);
		$display("done: address");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_fil();
		t_zero();
		t_offs();
		t_addr();
		end_sim();
	end
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		end_sim();
	end
endmodule // gzo_cmd_tb_top
